// ===== logic/seq_cfg.svh
// Build-time timing and sizing constants for the three-rail sequencer.
`ifndef SEQ_CFG_SVH
`define SEQ_CFG_SVH
`define SEQ_CLK_KHZ 20000
`define SEQ_TMR_W 22
`define SEQ_STEP_US_11MS 11000
`define SEQ_STEP_US_30MS 30000
`define SEQ_STEP_US_60MS 60000
`define SEQ_STEP_US_120MS 120000
`define SEQ_STEP_US_2P2MS 2200
`define SEQ_STEP_US_18MS 18000
`define SEQ_FIRST_OFS_US 400
`define SEQ_FIRST_OFS_US_SHORT 70
`define SEQ_RAILS_RESET 3'h0
`define SEQ_RAIL_NONE 2'h3
`endif

// ===== logic/seq_pkg.sv
// Types shared by the three-rail sequencer files.
package seq_pkg;
    typedef enum logic [2:0] {
        DLY_11MS, DLY_30MS, DLY_60MS, DLY_120MS, DLY_2P2MS, DLY_18MS
    } delay_option_type;
    typedef enum logic [2:0] {
        ORD_321, ORD_312, ORD_231, ORD_213, ORD_132, ORD_123
    } down_order_type;
    typedef enum logic [1:0] {
        ST_ALL_LOW, ST_UP_RUN, ST_ALL_HIGH, ST_DOWN_RUN
    } seq_state_type;
endpackage : seq_pkg

// ===== logic/step_timer.sv
// Down-counting step timer that pulses when a loaded delay has elapsed.
`timescale 1ns/1ps
`include "seq_cfg.svh"
module step_timer (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic load,
    input wire logic [`SEQ_TMR_W-1:0] load_val,
    output logic expired
);
    logic [`SEQ_TMR_W-1:0] cnt_q;
    logic expired_q;
    wire logic last_w = (cnt_q == `SEQ_TMR_W'(1));

    // A load of N makes expired pulse exactly N enabled cycles later.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q <= '0;
            expired_q <= 1'b0;
        end
        else if (ce)
        begin
            if (load)
                cnt_q <= load_val;
            else if (cnt_q != '0)
                cnt_q <= cnt_q - `SEQ_TMR_W'(1);
            expired_q <= last_w && !load;
        end
    end

    assign expired = expired_q;

    property p_expire_after_last;
        @(posedge clk) disable iff (rst)
        $rose(expired_q) |-> $past(last_w) && $past(ce);
    endproperty
    a_expire_after_last : assert property (p_expire_after_last) // see RQ5
        else $error("timer expired without reaching its last count");
endmodule : step_timer

// ===== logic/three_rail_power_sequencer.sv
// Three-rail open-drain power-up and power-down sequencer.
// Summary of operation
// RQ1 - Rails stay low until trigger first asserted.
// RQ2 - Power-up starts only on asserted trigger.
// RQ3 - Release rails a, b, c in order, timed.
// RQ4 - Pull rails low singly in build-time order.
// RQ5 - All step delays equal, build-time selected.
// RQ6 - Trigger drop aborts power-up, glitches never advance.
// RQ7 - First delay counts from last rising crossing.
// RQ8 - Mid-sequence change starts opposite sequence from state.
// RQ9 - Rail outputs are open-drain, low or released.
// RQ10 - First delay adds fixed offset to step.
// RQ11 - At most three sequencers chained externally.
// RQ12 - Controller keeps trigger low until supply valid.
// RQ13 - Timing by clock cycles, trigger synchronised first.
`timescale 1ns/1ps
`include "seq_cfg.svh"
module three_rail_power_sequencer #(
    parameter seq_pkg::delay_option_type delay_option = seq_pkg::DLY_11MS,
    parameter seq_pkg::down_order_type down_order = seq_pkg::ORD_321,
    parameter int unsigned step_cycles = (delay_option == seq_pkg::DLY_11MS)
        ? ((`SEQ_STEP_US_11MS * `SEQ_CLK_KHZ + 999) / 1000)
        : (delay_option == seq_pkg::DLY_30MS)
        ? ((`SEQ_STEP_US_30MS * `SEQ_CLK_KHZ + 999) / 1000)
        : (delay_option == seq_pkg::DLY_60MS)
        ? ((`SEQ_STEP_US_60MS * `SEQ_CLK_KHZ + 999) / 1000)
        : (delay_option == seq_pkg::DLY_120MS)
        ? 32'((64'(`SEQ_STEP_US_120MS) * `SEQ_CLK_KHZ + 999) / 1000)
        : (delay_option == seq_pkg::DLY_2P2MS)
        ? ((`SEQ_STEP_US_2P2MS * `SEQ_CLK_KHZ + 999) / 1000)
        : ((`SEQ_STEP_US_18MS * `SEQ_CLK_KHZ + 999) / 1000),
    parameter int unsigned first_offset_cycles =
        (delay_option == seq_pkg::DLY_2P2MS)
        ? ((`SEQ_FIRST_OFS_US_SHORT * `SEQ_CLK_KHZ + 999) / 1000)
        : ((`SEQ_FIRST_OFS_US * `SEQ_CLK_KHZ + 999) / 1000)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic trigger_in,
    output logic rail_out_a,
    output logic rail_out_a_oe_n,
    output logic rail_out_b,
    output logic rail_out_b_oe_n,
    output logic rail_out_c,
    output logic rail_out_c_oe_n
);
    // The timer flags one cycle before the rail moves, so it is loaded with
    // one cycle less than the wanted delay.
    localparam logic [`SEQ_TMR_W-1:0] STEP_LOAD = `SEQ_TMR_W'(step_cycles - 1);
    localparam logic [`SEQ_TMR_W-1:0] FIRST_LOAD =
        `SEQ_TMR_W'(step_cycles + first_offset_cycles - 1);

    // Returns the next rail to act on, or none when the sequence is done.
    function automatic logic [1:0] next_rail(
        input logic up,
        input logic [2:0] rel
    );
        logic [5:0] seq;
        logic [1:0] r;
        logic [1:0] pick;
        pick = `SEQ_RAIL_NONE;
        if (up)
            seq = {2'h2, 2'h1, 2'h0};
        else
        begin
            case (down_order)
                seq_pkg::ORD_321: seq = {2'h0, 2'h1, 2'h2};
                seq_pkg::ORD_312: seq = {2'h1, 2'h0, 2'h2};
                seq_pkg::ORD_231: seq = {2'h0, 2'h2, 2'h1};
                seq_pkg::ORD_213: seq = {2'h2, 2'h0, 2'h1};
                seq_pkg::ORD_132: seq = {2'h1, 2'h2, 2'h0};
                default: seq = {2'h2, 2'h1, 2'h0};
            endcase
        end
        for (int i = 2; i >= 0; i--)
        begin
            r = seq[2*i +: 2];
            if (rel[r] != up)
                pick = r;
        end
        return pick;
    endfunction : next_rail

    logic s1_q, s2_q, s3_q, trig_q;
    logic [2:0] rel_q, rel_d;
    seq_pkg::seq_state_type st_q, st_d;
    logic tmr_expired;

    // The pin passes three flops; a new level counts once two agree.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            trig_q <= 1'b0;
        end
        else if (ce)
        begin
            s1_q <= trigger_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) // see RQ13
                trig_q <= s3_q;
        end
    end

    wire logic trig_chg = (s2_q == s3_q) && (s3_q != trig_q);
    wire logic rising_w = trig_chg && s3_q;
    wire logic run_w = (st_q == seq_pkg::ST_UP_RUN) ||
                       (st_q == seq_pkg::ST_DOWN_RUN);
    wire logic up_w = (st_q == seq_pkg::ST_UP_RUN);
    wire logic [1:0] nx_w = next_rail(up_w, rel_q);
    wire logic [2:0] hot_w = 3'h1 << nx_w;
    wire logic [2:0] rel_step = up_w ? (rel_q | hot_w) : (rel_q & ~hot_w);
    wire logic [1:0] nx2_w = next_rail(up_w, rel_step);
    wire logic step_act = run_w && tmr_expired && !trig_chg;
    wire logic step_more = step_act && (nx2_w != `SEQ_RAIL_NONE);
    // Any settled trigger edge aborts the running sequence, and one that leaves a
    // rail to move restarts timing, so a ripple only ever restarts the count.
    wire logic start_w = trig_chg &&
        (next_rail(s3_q, rel_q) != `SEQ_RAIL_NONE); // see RQ6, RQ7, RQ8
    wire logic tmr_load = start_w || step_more;
    wire logic [`SEQ_TMR_W-1:0] tmr_val =
        start_w ? FIRST_LOAD : STEP_LOAD; // see RQ5, RQ10

    always_comb
    begin
        st_d = st_q;
        rel_d = rel_q;
        if (trig_chg)
        begin
            if (!start_w)
                st_d = s3_q ? seq_pkg::ST_ALL_HIGH : seq_pkg::ST_ALL_LOW;
            else if (rising_w) // see RQ2
                st_d = seq_pkg::ST_UP_RUN;
            else
                st_d = seq_pkg::ST_DOWN_RUN; // see RQ8
        end
        else if (step_act)
        begin
            rel_d = rel_step; // see RQ3, RQ4
            if (nx2_w == `SEQ_RAIL_NONE)
                st_d = up_w ? seq_pkg::ST_ALL_HIGH : seq_pkg::ST_ALL_LOW;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_q <= seq_pkg::ST_ALL_LOW;
            rel_q <= `SEQ_RAILS_RESET; // see RQ1
        end
        else if (ce)
        begin
            st_q <= st_d;
            rel_q <= rel_d;
        end
    end

    step_timer u_timer (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .load(tmr_load && ce),
        .load_val(tmr_val),
        .expired(tmr_expired)
    );

    // A held rail drives low; a released rail floats to its pull-up.
    assign rail_out_a = rel_q[0]; // see RQ9
    assign rail_out_a_oe_n = rel_q[0];
    assign rail_out_b = rel_q[1];
    assign rail_out_b_oe_n = rel_q[1];
    assign rail_out_c = rel_q[2];
    assign rail_out_c_oe_n = rel_q[2];

    property p_low_until_trigger;
        @(posedge clk) disable iff (rst)
        (st_q == seq_pkg::ST_ALL_LOW && !trig_q) |-> (rel_q == 3'h0);
    endproperty
    a_low_until_trigger : assert property (p_low_until_trigger) // see RQ1
        else $error("rail released while trigger never asserted");

    property p_release_needs_trig;
        @(posedge clk) disable iff (rst)
        (|(rel_q & ~$past(rel_q))) |-> $past(trig_q) && $past(tmr_expired);
    endproperty
    a_release_needs_trig : assert property (p_release_needs_trig) // see RQ2
        else $error("rail released without asserted trigger and timer");

    property p_up_order;
        @(posedge clk) disable iff (rst)
        ($rose(rel_q[1]) |-> rel_q[0]) and ($rose(rel_q[2]) |-> rel_q[1]);
    endproperty
    a_up_order : assert property (p_up_order) // see RQ3
        else $error("rails released out of order");

    property p_one_at_a_time;
        @(posedge clk) disable iff (rst)
        $countones(rel_q ^ $past(rel_q)) <= 1;
    endproperty
    a_one_at_a_time : assert property (p_one_at_a_time) // see RQ4
        else $error("more than one rail changed in one cycle");

    property p_fall_drops_no_trig;
        @(posedge clk) disable iff (rst)
        (|($past(rel_q) & ~rel_q)) |-> !$past(trig_q);
    endproperty
    a_fall_drops_no_trig : assert property (p_fall_drops_no_trig) // see RQ4
        else $error("rail pulled low while trigger asserted");

    property p_edge_restarts_first;
        @(posedge clk) disable iff (rst)
        (ce && start_w) |=> (u_timer.cnt_q == FIRST_LOAD);
    endproperty
    a_edge_restarts_first : assert property (p_edge_restarts_first) // see RQ7
        else $error("trigger edge did not restart the first delay");

    property p_abort_up;
        @(posedge clk) disable iff (rst)
        (ce && st_q == seq_pkg::ST_UP_RUN && trig_chg && start_w)
        |=> (st_q == seq_pkg::ST_DOWN_RUN) && (rel_q == $past(rel_q));
    endproperty
    a_abort_up : assert property (p_abort_up) // see RQ6
        else $error("trigger drop did not abort power-up");

    property p_abort_down;
        @(posedge clk) disable iff (rst)
        (ce && st_q == seq_pkg::ST_DOWN_RUN && trig_chg && start_w)
        |=> (st_q == seq_pkg::ST_UP_RUN) && (rel_q == $past(rel_q));
    endproperty
    a_abort_down : assert property (p_abort_down) // see RQ8
        else $error("trigger rise did not abort power-down");

    property p_sync_agree;
        @(posedge clk) disable iff (rst)
        (trig_q != $past(trig_q)) |-> $past(s2_q == s3_q);
    endproperty
    a_sync_agree : assert property (p_sync_agree) // see RQ13
        else $error("trigger accepted before synchroniser agreed");

    property p_pins_open_drain;
        @(posedge clk) disable iff (rst)
        (rail_out_a_oe_n == rel_q[0]) && (rail_out_b_oe_n == rel_q[1]) &&
        (rail_out_c_oe_n == rel_q[2]) && !(rail_out_a && !rail_out_a_oe_n);
    endproperty
    a_pins_open_drain : assert property (p_pins_open_drain) // see RQ9
        else $error("rail pin drive does not match rail state");
endmodule : three_rail_power_sequencer

// ===== testbench/rail_pullup.sv
// Pull-up network on the three open-drain rail pins.
`timescale 1ns/1ps
module rail_pullup (
    input wire logic [2:0] oe_n,
    input wire logic [2:0] drive,
    output logic [2:0] level
);
    // A released pin is lifted by its resistor, a driven pin shows the drive.
    assign level = oe_n | drive;
endmodule : rail_pullup

// ===== testbench/tb.sv
// Self-checking bench: all six power-down orders and one chained stage.
`timescale 1ns/1ps
`define CHECK(what, exp, got) \
    begin \
        check_count++; \
        if ((got) !== (exp)) \
        begin \
            mismatches++; \
            $display("[FAIL] %s expected %h seen %h", what, exp, got); \
        end \
    end
module tb;
    typedef struct {
        logic trig;
        int wait_n;
        bit up;
        int n;
        logic [2:0] chain;
    } row_type;
    // Rail indices in pull-down order, first step in the low bits.
    localparam logic [5:0] pick [0:5] =
        '{6'h06, 6'h12, 6'h09, 6'h21, 6'h18, 6'h24};
    logic clk;
    logic rst;
    logic ce = 1'b1;
    logic trigger_in;
    logic [2:0] oe_n [7];
    logic [2:0] rails [7];
    logic [2:0] level [7];
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    row_type rows [12] = '{
        '{1'b1, 26, 1'b1, 0, 3'h0}, '{1'b1, 5, 1'b1, 1, 3'h0},
        '{1'b1, 15, 1'b1, 1, 3'h0}, '{1'b1, 5, 1'b1, 2, 3'h0},
        '{1'b1, 15, 1'b1, 2, 3'h0}, '{1'b1, 5, 1'b1, 3, 3'h0},
        '{1'b0, 26, 1'b0, 0, 3'h0}, '{1'b0, 5, 1'b0, 1, 3'h1},
        '{1'b0, 15, 1'b0, 1, 3'h1}, '{1'b0, 5, 1'b0, 2, 3'h1},
        '{1'b0, 15, 1'b0, 2, 3'h0}, '{1'b0, 5, 1'b0, 3, 3'h0}};

    // Instance six is a second stage triggered by rail c of instance zero.
    for (genvar g = 0; g < 7; g++)
    begin : gen_dut
        three_rail_power_sequencer #(
            .down_order(seq_pkg::down_order_type'(g % 6)),
            .step_cycles(20),
            .first_offset_cycles(5)
        ) dut (
            .clk(clk), .rst(rst), .ce(ce),
            .trigger_in(g == 6 ? level[0][2] : trigger_in),
            .rail_out_a(rails[g][0]), .rail_out_a_oe_n(oe_n[g][0]),
            .rail_out_b(rails[g][1]), .rail_out_b_oe_n(oe_n[g][1]),
            .rail_out_c(rails[g][2]), .rail_out_c_oe_n(oe_n[g][2])
        );
        rail_pullup load (.oe_n(oe_n[g]), .drive(rails[g]), .level(level[g]));
    end

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    function automatic logic [2:0] expect_val(int g, bit up, int n);
        logic [2:0] v;
        v = up ? 3'h0 : 3'h7;
        for (int k = 0; k < n; k++)
            v[up ? k : pick[g][2*k+:2]] = up;
        return v;
    endfunction : expect_val

    task automatic step(input logic trig, input int wait_n, input bit up,
                        input int n, input string what);
        trigger_in = trig;
        repeat (wait_n) @(posedge clk);
        #5;
        for (int g = 0; g < 6; g++)
        begin
            `CHECK(what, expect_val(g, up, n), level[g])
            `CHECK(what, level[g], rails[g])
        end
    endtask : step

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 1500)
        begin
            mismatches++;
            summarize();
        end
    end

    initial
    begin
        rst = 1'b1;
        trigger_in = 1'b0;
        repeat (12) @(posedge clk);
        #5;
        `CHECK("reset", 3'h0, level[0])
        rst = 1'b0;
        step(1'b0, 40, 1'b1, 0, "idle");
        $display("Test reset done");
        foreach (rows[i])
        begin
            step(rows[i].trig, rows[i].wait_n, rows[i].up, rows[i].n, "row");
            `CHECK("chain", rows[i].chain, level[6])
        end
        $display("Test rows done");
        // Single-cycle pulses never settle in the synchroniser.
        repeat (2)
        begin
            trigger_in = 1'b1;
            @(posedge clk);
            #5;
            trigger_in = 1'b0;
            @(posedge clk);
            #5;
        end
        step(1'b0, 40, 1'b1, 0, "glitch");
        // A settled rise and fall come first; only the last rise sets timing.
        step(1'b1, 5, 1'b1, 0, "ripple");
        step(1'b0, 5, 1'b1, 0, "ripple");
        step(1'b1, 26, 1'b1, 0, "last rise");
        step(1'b1, 5, 1'b1, 1, "last rise");
        $display("Test glitch done");
        step(1'b0, 26, 1'b1, 1, "abort up");
        step(1'b0, 5, 1'b1, 0, "abort up");
        step(1'b1, 71, 1'b1, 3, "full up");
        step(1'b0, 31, 1'b0, 1, "abort down");
        step(1'b1, 26, 1'b0, 1, "abort down");
        step(1'b1, 5, 1'b1, 3, "abort down");
        $display("Test abort done");
        rst = 1'b1;
        #10;
        `CHECK("async reset", 3'h0, level[0])
        @(posedge clk);
        #5;
        rst = 1'b0;
        step(1'b1, 26, 1'b1, 0, "after reset");
        ce = 1'b0;
        step(1'b1, 5, 1'b1, 0, "freeze");
        ce = 1'b1;
        step(1'b1, 5, 1'b1, 1, "after reset");
        $display("Test second reset done");
        summarize();
    end
endmodule : tb
